// [omc_far_side.sv]
`timescale 1ns/1ps
module omc_far_side (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Requests from the bench
  input wire logic [15:0] irq_raise,
  input wire logic irq_clear,
  input wire logic src_run,
  // Pulse from the controller
  input wire logic time_base_irq,
  // Towards the controller
  output logic [15:0] irq_latches,
  output logic [3:0] time_base_src
);
  // ---------------------------------------------
  // Interrupt latches and time base sources
  // ---------------------------------------------
  logic [7:0] div_q;

  // Latches hold until cleared; bit 5 is the time base latch.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_latches <= 16'h0000;
    end else if (irq_clear) begin
      irq_latches <= 16'h0000;
    end else begin
      irq_latches <= irq_latches | irq_raise | {10'h000, time_base_irq, 5'h00};
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  // Sources rest high while parked, so a halt only ends when the bench asks.
  assign time_base_src = src_run ? div_q[6:3] : 4'hf;
endmodule

// [omc_operating_mode_controller.sv]
// Implementation choices: strobed register access and the address map.
`timescale 1ns/1ps
module omc_operating_mode_controller (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Interrupt controller
  input wire logic [15:0] irq_latches,
  input wire logic [15:0] interrupt_enable_reg,
  input wire logic master_irq_enable,
  input wire logic time_base_irq_enable,
  output logic wake_service_irq,
  output logic time_base_irq,
  output logic warmup_done_irq,
  // Asynchronous inputs
  input wire logic [3:0] time_base_src,
  input wire logic stop_release,
  // Clock gating and status
  output logic cpu_clk_en,
  output logic wdt_clk_en,
  output logic tbt_clk_en,
  output logic periph_clk_en,
  output logic main_clk_tick,
  output logic main_clk_from_slow,
  output logic prescaler_hold,
  output logic high_osc_run,
  output logic low_osc_run,
  output logic low_osc_pins_as_port,
  output logic [3:0] mode_code
);

  omc_pkg::omc_mode_type mode_q, mode_d, saved_mode_q;
  logic [7:0] ctrl_two_q, tb_ctrl_q, wu_cmp_q;
  logic stop_req_q, tb_armed_q;
  localparam int OMC_WU_BITS_W = omc_pkg::OMC_WU_BITS;
  logic [OMC_WU_BITS_W-1:0] wu_cnt_q;
  logic wu_run_q;
  logic [1:0] slow_div_q;
  logic [3:0] tb_s1_q, tb_s2_q, tb_s3_q;
  logic rel_s1_q, rel_s2_q;
  logic tb_fall, tb_wake, tb_pend_q, any_wake, tick;

  // ---------------------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tb_s1_q <= 4'h0;
      tb_s2_q <= 4'h0;
      tb_s3_q <= 4'h0;
      rel_s1_q <= 1'b0;
      rel_s2_q <= 1'b0;
    end else begin
      tb_s1_q <= time_base_src;
      tb_s2_q <= tb_s1_q;
      tb_s3_q <= tb_s2_q;
      rel_s1_q <= stop_release;
      rel_s2_q <= rel_s1_q;
    end
  end

  function automatic logic sel_bit(input logic [3:0] v, input logic [1:0] s);
    sel_bit = v[s];
  endfunction

  // Edge on the selected time base source only.
  assign tb_fall = sel_bit(tb_s3_q, tb_ctrl_q[1:0]) & ~sel_bit(tb_s2_q, tb_ctrl_q[1:0]);
  assign any_wake = |(irq_latches & interrupt_enable_reg);
  assign tb_wake = tb_fall | tb_pend_q;

  // ---------------------------------------------------------------------------
  // Main system clock tick
  // ---------------------------------------------------------------------------
  // Slow modes advance once every four cycles, standing in for fs/4.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      slow_div_q <= 2'd0;
    end else begin
      slow_div_q <= slow_div_q + 2'd1;
    end
  end

  always_comb begin
    main_clk_from_slow = 1'b0;
    case (mode_q)
      omc_pkg::OMC_SLOW_RUN_FAST_OSC_ON, omc_pkg::OMC_SLOW_ONLY_RUN,
      omc_pkg::OMC_SLOW_CPU_HALT, omc_pkg::OMC_SLOW_DEEP_HALT: begin
        main_clk_from_slow = 1'b1;
      end
      default: begin
        main_clk_from_slow = 1'b0;
      end
    endcase
  end

  assign tick = main_clk_from_slow ? (slow_div_q == omc_pkg::OMC_SLOW_DIV_LAST) : 1'b1;
  assign main_clk_tick = tick;

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_two_q <= omc_pkg::OMC_CTRL_TWO_RESET;
      tb_ctrl_q <= omc_pkg::OMC_TB_CTRL_RESET;
      wu_cmp_q <= omc_pkg::OMC_WU_CMP_RESET;
      stop_req_q <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == omc_pkg::OMC_ADDR_CTRL_TWO) begin
        ctrl_two_q <= reg_wdata;
      end else if (tick && mode_q != mode_d) begin
        // Request bits self-clear once the mode has been taken.
        ctrl_two_q[omc_pkg::OMC_BIT_IDLE] <= 1'b0;
        ctrl_two_q[omc_pkg::OMC_BIT_TG_HALT] <= 1'b0;
      end
      if (reg_wr && reg_addr == omc_pkg::OMC_ADDR_TB_CTRL) begin
        tb_ctrl_q <= reg_wdata;
      end
      if (reg_wr && reg_addr == omc_pkg::OMC_ADDR_WU_CMP) begin
        wu_cmp_q <= reg_wdata;
      end
      if (reg_wr && reg_addr == omc_pkg::OMC_ADDR_CTRL_ONE) begin
        stop_req_q <= reg_wdata[omc_pkg::OMC_BIT_STOP];
      end else if (mode_q == omc_pkg::OMC_STOP) begin
        stop_req_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        omc_pkg::OMC_ADDR_CTRL_ONE: reg_rdata <= {stop_req_q, 7'h00};
        omc_pkg::OMC_ADDR_CTRL_TWO: reg_rdata <= ctrl_two_q;
        omc_pkg::OMC_ADDR_TB_CTRL: reg_rdata <= tb_ctrl_q;
        omc_pkg::OMC_ADDR_WU_CMP: reg_rdata <= wu_cmp_q;
        omc_pkg::OMC_ADDR_STATUS: reg_rdata <= {4'h0, mode_q};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ---------------------------------------------------------------------------
  // Mode state machine
  // ---------------------------------------------------------------------------
  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      omc_pkg::OMC_SINGLE_FULL_RUN: begin
        if (stop_req_q) begin
          mode_d = omc_pkg::OMC_STOP;
        end else if (ctrl_two_q[omc_pkg::OMC_BIT_TG_HALT]) begin
          mode_d = omc_pkg::OMC_SINGLE_DEEP_HALT;
        end else if (ctrl_two_q[omc_pkg::OMC_BIT_IDLE]) begin
          mode_d = omc_pkg::OMC_SINGLE_CPU_HALT;
        end else if (ctrl_two_q[omc_pkg::OMC_BIT_LOW_OSC_EN]) begin
          mode_d = omc_pkg::OMC_DUAL_FAST_RUN;
        end
      end
      omc_pkg::OMC_SINGLE_CPU_HALT: begin
        if (any_wake) mode_d = omc_pkg::OMC_SINGLE_FULL_RUN;
      end
      omc_pkg::OMC_SINGLE_DEEP_HALT: begin
        if (tb_wake) mode_d = omc_pkg::OMC_SINGLE_FULL_RUN;
      end
      omc_pkg::OMC_DUAL_FAST_RUN: begin
        if (stop_req_q) begin
          mode_d = omc_pkg::OMC_STOP;
        end else if (ctrl_two_q[omc_pkg::OMC_BIT_IDLE]) begin
          mode_d = omc_pkg::OMC_DUAL_CPU_HALT;
        end else if (ctrl_two_q[omc_pkg::OMC_BIT_SYS_CLK_SEL]) begin
          mode_d = omc_pkg::OMC_SLOW_RUN_FAST_OSC_ON;
        end else if (!ctrl_two_q[omc_pkg::OMC_BIT_LOW_OSC_EN]) begin
          mode_d = omc_pkg::OMC_SINGLE_FULL_RUN;
        end
      end
      omc_pkg::OMC_DUAL_CPU_HALT: begin
        if (any_wake) mode_d = omc_pkg::OMC_DUAL_FAST_RUN;
      end
      omc_pkg::OMC_SLOW_RUN_FAST_OSC_ON: begin
        if (stop_req_q) begin
          mode_d = omc_pkg::OMC_STOP;
        end else if (!ctrl_two_q[omc_pkg::OMC_BIT_SYS_CLK_SEL]) begin
          mode_d = omc_pkg::OMC_DUAL_FAST_RUN;
        end else if (!ctrl_two_q[omc_pkg::OMC_BIT_HIGH_OSC_EN]) begin
          mode_d = omc_pkg::OMC_SLOW_ONLY_RUN;
        end
      end
      omc_pkg::OMC_SLOW_ONLY_RUN: begin
        if (stop_req_q) begin
          mode_d = omc_pkg::OMC_STOP;
        end else if (ctrl_two_q[omc_pkg::OMC_BIT_TG_HALT]) begin
          mode_d = omc_pkg::OMC_SLOW_DEEP_HALT;
        end else if (ctrl_two_q[omc_pkg::OMC_BIT_IDLE]) begin
          mode_d = omc_pkg::OMC_SLOW_CPU_HALT;
        end else if (ctrl_two_q[omc_pkg::OMC_BIT_HIGH_OSC_EN]) begin
          mode_d = omc_pkg::OMC_SLOW_RUN_FAST_OSC_ON;
        end
      end
      omc_pkg::OMC_SLOW_CPU_HALT: begin
        if (any_wake) mode_d = omc_pkg::OMC_SLOW_ONLY_RUN;
      end
      omc_pkg::OMC_SLOW_DEEP_HALT: begin
        if (tb_wake) mode_d = omc_pkg::OMC_SLOW_ONLY_RUN;
      end
      omc_pkg::OMC_STOP: begin
        if (rel_s2_q) mode_d = omc_pkg::OMC_STOP_WARMUP;
      end
      omc_pkg::OMC_STOP_WARMUP: begin
        if (wu_cnt_q[OMC_WU_BITS_W-1 -: 8] == wu_cmp_q) mode_d = saved_mode_q;
      end
      default: begin
        mode_d = omc_pkg::OMC_SINGLE_FULL_RUN;
      end
    endcase
  end

  // Stop and warm-up run on the system clock, so they ignore the slow tick.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= omc_pkg::OMC_SINGLE_FULL_RUN;
    end else if (tick || mode_q == omc_pkg::OMC_STOP || mode_q == omc_pkg::OMC_STOP_WARMUP) begin
      mode_q <= mode_d;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      saved_mode_q <= omc_pkg::OMC_SINGLE_FULL_RUN;
    end else if (tick && mode_d == omc_pkg::OMC_STOP && mode_q != omc_pkg::OMC_STOP) begin
      saved_mode_q <= mode_q;
    end
  end

  // ---------------------------------------------------------------------------
  // Time base latch after deep halt
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tb_armed_q <= 1'b0;
      time_base_irq <= 1'b0;
      tb_pend_q <= 1'b0;
    end else begin
      time_base_irq <= 1'b0;
      // Slow ticks come one cycle in four; an edge between them waits for the next tick.
      tb_pend_q <= tb_wake && !tick;
      if (tick && (mode_d == omc_pkg::OMC_SINGLE_DEEP_HALT ||
                   mode_d == omc_pkg::OMC_SLOW_DEEP_HALT) && mode_q != mode_d) begin
        tb_armed_q <= tb_ctrl_q[omc_pkg::OMC_BIT_TB_EN];
      end else if (tick && tb_wake && (mode_q == omc_pkg::OMC_SINGLE_DEEP_HALT ||
                                       mode_q == omc_pkg::OMC_SLOW_DEEP_HALT)) begin
        tb_armed_q <= 1'b0;
        time_base_irq <= tb_armed_q;
      end
    end
  end

  // Wake services an interrupt only if the CPU would take it; else it resumes.
  assign wake_service_irq = master_irq_enable & (any_wake | (time_base_irq & time_base_irq_enable));

  // ---------------------------------------------------------------------------
  // Warm-up counter
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wu_cnt_q <= '0;
      wu_run_q <= 1'b0;
      warmup_done_irq <= 1'b0;
    end else begin
      warmup_done_irq <= 1'b0;
      if (reg_wr && reg_addr == omc_pkg::OMC_ADDR_CTRL_TWO &&
          ((reg_wdata[omc_pkg::OMC_BIT_HIGH_OSC_EN] & ~ctrl_two_q[omc_pkg::OMC_BIT_HIGH_OSC_EN]) |
           (reg_wdata[omc_pkg::OMC_BIT_LOW_OSC_EN] & ~ctrl_two_q[omc_pkg::OMC_BIT_LOW_OSC_EN]))) begin
        wu_run_q <= 1'b1;
        wu_cnt_q <= '0;
      end else if (mode_q == omc_pkg::OMC_STOP_WARMUP) begin
        wu_cnt_q <= (mode_d != mode_q) ? '0 : wu_cnt_q + 1'b1;
      end else if (wu_run_q && mode_q != omc_pkg::OMC_STOP) begin
        if (wu_cnt_q[OMC_WU_BITS_W-1 -: 8] == wu_cmp_q) begin
          warmup_done_irq <= 1'b1;
          wu_run_q <= 1'b0;
          wu_cnt_q <= '0;
        end else begin
          wu_cnt_q <= wu_cnt_q + 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Clock gates and oscillators
  // ---------------------------------------------------------------------------
  always_comb begin
    cpu_clk_en = 1'b0;
    periph_clk_en = 1'b0;
    tbt_clk_en = 1'b0;
    case (mode_q)
      omc_pkg::OMC_SINGLE_FULL_RUN, omc_pkg::OMC_DUAL_FAST_RUN,
      omc_pkg::OMC_SLOW_RUN_FAST_OSC_ON, omc_pkg::OMC_SLOW_ONLY_RUN: begin
        cpu_clk_en = tick;
        periph_clk_en = tick;
        tbt_clk_en = tick;
      end
      omc_pkg::OMC_SINGLE_CPU_HALT, omc_pkg::OMC_DUAL_CPU_HALT,
      omc_pkg::OMC_SLOW_CPU_HALT: begin
        periph_clk_en = tick;
        tbt_clk_en = tick;
      end
      omc_pkg::OMC_SINGLE_DEEP_HALT, omc_pkg::OMC_SLOW_DEEP_HALT: begin
        tbt_clk_en = tick;
      end
      default: begin
        cpu_clk_en = 1'b0;
      end
    endcase
  end

  assign wdt_clk_en = cpu_clk_en;
  assign prescaler_hold = mode_q == omc_pkg::OMC_SLOW_RUN_FAST_OSC_ON ||
                          mode_q == omc_pkg::OMC_SLOW_ONLY_RUN ||
                          mode_q == omc_pkg::OMC_SLOW_CPU_HALT;
  assign high_osc_run = !(mode_q == omc_pkg::OMC_SLOW_ONLY_RUN ||
                          mode_q == omc_pkg::OMC_SLOW_CPU_HALT ||
                          mode_q == omc_pkg::OMC_SLOW_DEEP_HALT ||
                          mode_q == omc_pkg::OMC_STOP);
  assign low_osc_pins_as_port = mode_q == omc_pkg::OMC_SINGLE_FULL_RUN ||
                                mode_q == omc_pkg::OMC_SINGLE_CPU_HALT ||
                                mode_q == omc_pkg::OMC_SINGLE_DEEP_HALT ||
                                (mode_q == omc_pkg::OMC_STOP_WARMUP && !ctrl_two_q[6]) ||
                                (mode_q == omc_pkg::OMC_STOP && !ctrl_two_q[6]);
  assign low_osc_run = !low_osc_pins_as_port && mode_q != omc_pkg::OMC_STOP;
  assign mode_code = mode_q;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  sequence idle_taken_s;
    tick && mode_q == omc_pkg::OMC_SINGLE_FULL_RUN && !stop_req_q &&
    !ctrl_two_q[omc_pkg::OMC_BIT_TG_HALT] && ctrl_two_q[omc_pkg::OMC_BIT_IDLE];
  endsequence

  reset_mode_a: assert property (@(posedge clk_sys) $rose(rst_n) |->
    mode_q == omc_pkg::OMC_SINGLE_FULL_RUN) else $error("reset mode wrong");
  idle_entry_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    idle_taken_s |=> mode_q == omc_pkg::OMC_SINGLE_CPU_HALT && !cpu_clk_en && periph_clk_en)
    else $error("idle entry wrong");
  halt_wake_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    mode_q == omc_pkg::OMC_SINGLE_CPU_HALT && any_wake |=> mode_q == omc_pkg::OMC_SINGLE_FULL_RUN)
    else $error("halt not released");
  deep_exit_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    mode_q == omc_pkg::OMC_SINGLE_DEEP_HALT && tb_fall |=> mode_q == omc_pkg::OMC_SINGLE_FULL_RUN
    && periph_clk_en) else $error("deep halt exit wrong");
  deep_gate_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    mode_q == omc_pkg::OMC_SINGLE_DEEP_HALT |-> !periph_clk_en && tbt_clk_en)
    else $error("deep halt gating wrong");
  slow_clock_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    mode_q == omc_pkg::OMC_SLOW_ONLY_RUN && cpu_clk_en |=> !cpu_clk_en [*3])
    else $error("slow clock not quarter");
  stop_quiet_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    mode_q == omc_pkg::OMC_STOP |-> !high_osc_run && !low_osc_run && !cpu_clk_en)
    else $error("stop not quiet");
  prescale_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    main_clk_from_slow && mode_q != omc_pkg::OMC_SLOW_DEEP_HALT |-> prescaler_hold)
    else $error("prescaler running in slow");
  warmup_irq_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    warmup_done_irq |-> !wu_run_q && wu_cnt_q == '0) else $error("warm-up not cleared");

endmodule

// [omc_pkg.sv]
package omc_pkg;

  // ---------------------------------------------------------------------------
  // Operating modes
  // ---------------------------------------------------------------------------
  typedef enum logic [3:0] {
    OMC_SINGLE_FULL_RUN,
    OMC_SINGLE_CPU_HALT,
    OMC_SINGLE_DEEP_HALT,
    OMC_DUAL_FAST_RUN,
    OMC_DUAL_CPU_HALT,
    OMC_SLOW_RUN_FAST_OSC_ON,
    OMC_SLOW_ONLY_RUN,
    OMC_SLOW_CPU_HALT,
    OMC_SLOW_DEEP_HALT,
    OMC_STOP,
    OMC_STOP_WARMUP
  } omc_mode_type;

  // ---------------------------------------------------------------------------
  // Register offsets and fields
  // ---------------------------------------------------------------------------
  localparam logic [3:0] OMC_ADDR_CTRL_ONE = 4'h0;
  localparam logic [3:0] OMC_ADDR_CTRL_TWO = 4'h1;
  localparam logic [3:0] OMC_ADDR_TB_CTRL = 4'h2;
  localparam logic [3:0] OMC_ADDR_WU_CMP = 4'h3;
  localparam logic [3:0] OMC_ADDR_STATUS = 4'h4;

  localparam int OMC_BIT_STOP = 7;
  localparam int OMC_BIT_HIGH_OSC_EN = 7;
  localparam int OMC_BIT_LOW_OSC_EN = 6;
  localparam int OMC_BIT_SYS_CLK_SEL = 5;
  localparam int OMC_BIT_IDLE = 4;
  localparam int OMC_BIT_TG_HALT = 2;
  localparam int OMC_BIT_TB_EN = 3;
  localparam int OMC_TB_SEL_LSB = 0;

  localparam logic [7:0] OMC_CTRL_TWO_RESET = 8'h80;
  localparam logic [7:0] OMC_TB_CTRL_RESET = 8'h00;
  localparam logic [7:0] OMC_WU_CMP_RESET = 8'h66;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int OMC_WU_BITS = 14;
  localparam int OMC_SLOW_DIV = 4;
  localparam logic [1:0] OMC_SLOW_DIV_LAST = 2'(OMC_SLOW_DIV - 1);

endpackage

// [operating_mode_controller_bench.sv]
`timescale 1ns/1ps
module operating_mode_controller_bench;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] interrupt_enable_reg = 16'h0000;
  logic master_irq_enable = 1'b0;
  logic time_base_irq_enable = 1'b0;
  logic stop_release = 1'b0;
  logic [15:0] irq_raise = 16'h0000;
  logic irq_clear = 1'b0;
  logic src_run = 1'b0;
  logic [7:0] reg_rdata;
  logic [15:0] irq_latches;
  logic [3:0] time_base_src;
  logic [3:0] mode_code;
  logic wake_service_irq, time_base_irq, warmup_done_irq, cpu_clk_en, wdt_clk_en;
  logic tbt_clk_en, periph_clk_en, main_clk_tick, main_clk_from_slow, prescaler_hold;
  logic high_osc_run, low_osc_run, low_osc_pins_as_port;
  logic rd_q = 1'b0;
  logic [7:0] exp_q[$];
  logic [31:0] rng = 32'hfd62_177b;
  int fail_count = 0;
  int n_tests = 0;
  int tb_pulses = 0;
  int wu_pulses = 0;
  int n0;
  int ticks;

  always #12.5 clk_sys = ~clk_sys;

  omc_operating_mode_controller omc_operating_mode_controller_inst (.clk_sys, .rst_n,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq_latches,
    .interrupt_enable_reg, .master_irq_enable, .time_base_irq_enable, .wake_service_irq,
    .time_base_irq, .warmup_done_irq, .time_base_src, .stop_release, .cpu_clk_en,
    .wdt_clk_en, .tbt_clk_en, .periph_clk_en, .main_clk_tick, .main_clk_from_slow,
    .prescaler_hold, .high_osc_run, .low_osc_run, .low_osc_pins_as_port, .mode_code);

  omc_far_side omc_far_side_inst (.clk_sys, .rst_n, .irq_raise, .irq_clear, .src_run,
    .time_base_irq, .irq_latches, .time_base_src);

  // ---------------------------------------------
  // Checking and reporting
  // ---------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // Read data stand only in the cycle after the strobe, so look at mid-cycle.
  always @(posedge clk_sys) rd_q <= reg_rd;
  always @(negedge clk_sys) begin
    if (rd_q) chk(reg_rdata, exp_q.pop_front());
  end

  always @(posedge clk_sys) begin
    if (time_base_irq === 1'b1) tb_pulses <= tb_pulses + 1;
    if (warmup_done_irq === 1'b1) wu_pulses <= wu_pulses + 1;
  end

  initial begin
    repeat (100000) @(posedge clk_sys);
    fail_count++;
    complete_run();
  end

  // ---------------------------------------------
  // Bus and mode tasks
  // ---------------------------------------------
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk_sys);
    reg_rd <= 1'b0;
  endtask

  // Waits for a mode under a bound, confirms it through the status register.
  task automatic wm(input logic [3:0] m);
    int i;
    for (i = 0; i < 600 && mode_code !== m; i++) @(negedge clk_sys);
    if (mode_code !== m) begin
      fail_count++;
      $display("wrong value at %0t: mode %h never reached", $time, m);
      complete_run();
    end
    rd(omc_pkg::OMC_ADDR_STATUS, {4'h0, m});
    @(negedge clk_sys);
  endtask

  task automatic go(input logic [3:0] a, input logic [7:0] d, input logic [3:0] m);
    wr(a, d);
    wm(m);
  endtask

  task automatic halt_wake(input logic [7:0] c2, input logic [3:0] hm, input logic [3:0] rm);
    logic [15:0] b;
    rng = xs(rng);
    b = 16'h0001 << rng[3:0];
    @(posedge clk_sys);
    irq_clear <= 1'b1;
    @(posedge clk_sys);
    irq_clear <= 1'b0;
    interrupt_enable_reg <= ~b;
    master_irq_enable <= rng[8];
    go(omc_pkg::OMC_ADDR_CTRL_TWO, c2, hm);
    chk(cpu_clk_en | wdt_clk_en, 1'b0);
    @(posedge clk_sys);
    irq_raise <= b;
    @(posedge clk_sys);
    irq_raise <= 16'h0000;
    repeat (12) @(negedge clk_sys);
    chk(mode_code, hm);
    @(posedge clk_sys);
    interrupt_enable_reg <= b;
    wm(rm);
    chk(wake_service_irq, rng[8]);
  endtask

  task automatic deep(input logic [7:0] c2, input logic [3:0] hm, input logic [3:0] rm);
    logic [7:0] tc;
    rng = xs(rng);
    tc = {4'h0, rng[9], 1'b0, rng[1:0]};
    @(posedge clk_sys);
    irq_clear <= 1'b1;
    time_base_irq_enable <= rng[10];
    interrupt_enable_reg <= {10'h000, rng[10], 5'h00};
    master_irq_enable <= rng[11];
    @(posedge clk_sys);
    irq_clear <= 1'b0;
    wr(omc_pkg::OMC_ADDR_TB_CTRL, tc);
    rd(omc_pkg::OMC_ADDR_TB_CTRL, tc);
    n0 = tb_pulses;
    go(omc_pkg::OMC_ADDR_CTRL_TWO, c2, hm);
    chk(cpu_clk_en | periph_clk_en, 1'b0);
    @(posedge clk_sys);
    src_run <= 1'b1;
    wm(rm);
    @(posedge clk_sys);
    src_run <= 1'b0;
    repeat (20) @(negedge clk_sys);
    chk(8'(tb_pulses - n0), {7'h00, rng[9]});
    chk(wake_service_irq, rng[9] & rng[10] & rng[11]);
  endtask

  // ---------------------------------------------
  // Main sequence
  // ---------------------------------------------
  initial begin
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(negedge clk_sys);
    chk(mode_code, 4'h0);
    chk(cpu_clk_en & periph_clk_en, 1'b1);
    chk(low_osc_pins_as_port, 1'b1);
    rd(omc_pkg::OMC_ADDR_CTRL_TWO, omc_pkg::OMC_CTRL_TWO_RESET);
    rd(omc_pkg::OMC_ADDR_WU_CMP, omc_pkg::OMC_WU_CMP_RESET);
    rd(4'hf, 8'h00);
    halt_wake(8'h90, 4'h1, 4'h0);
    deep(8'h84, 4'h2, 4'h0);
    deep(8'h84, 4'h2, 4'h0);
    // A short warm-up compare keeps the software warm-up within the wait below.
    wr(omc_pkg::OMC_ADDR_WU_CMP, 8'h02);
    n0 = wu_pulses;
    go(omc_pkg::OMC_ADDR_CTRL_TWO, 8'hc0, 4'h3);
    chk(low_osc_pins_as_port, 1'b0);
    repeat (300) @(negedge clk_sys);
    chk(8'(wu_pulses - n0), 8'h01);
    halt_wake(8'hd0, 4'h4, 4'h3);
    go(omc_pkg::OMC_ADDR_CTRL_TWO, 8'he0, 4'h5);
    ticks = 0;
    repeat (16) begin
      @(negedge clk_sys);
      if (main_clk_tick === 1'b1) ticks++;
    end
    chk(8'(ticks), 8'h04);
    chk(prescaler_hold & main_clk_from_slow, 1'b1);
    go(omc_pkg::OMC_ADDR_CTRL_TWO, 8'h60, 4'h6);
    chk({high_osc_run, prescaler_hold}, 8'h01);
    halt_wake(8'h70, 4'h7, 4'h6);
    chk(prescaler_hold, 1'b1);
    deep(8'h64, 4'h8, 4'h6);
    n0 = wu_pulses;
    go(omc_pkg::OMC_ADDR_CTRL_TWO, 8'he0, 4'h5);
    go(omc_pkg::OMC_ADDR_CTRL_TWO, 8'hc0, 4'h3);
    // The fast oscillator warm-up must end before stop, or stop would resume its count.
    repeat (150) @(negedge clk_sys);
    chk(8'(wu_pulses - n0), 8'h01);
    go(omc_pkg::OMC_ADDR_CTRL_ONE, 8'h80, 4'h9);
    chk(high_osc_run | low_osc_run | cpu_clk_en | periph_clk_en, 1'b0);
    @(posedge clk_sys);
    stop_release <= 1'b1;
    wm(4'ha);
    @(posedge clk_sys);
    stop_release <= 1'b0;
    wm(4'h3);
    complete_run();
  end
endmodule
